// ===== core/fus_sequencer.sv
// Flash unlock and write sequencer with AXI4-Lite register slave
`include "fus_defs.svh"
`default_nettype none
module fus_sequencer (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [`FUS_AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`FUS_AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output var fus_pkg::fus_flash_s flash,
   input wire logic flash_done,
   output logic cpu_stall
);
   localparam fus_pkg::fus_latch_t ERASED_ROW =
      {`FUS_ROW_WORDS{`FUS_LATCH_ERASED}};

   fus_pkg::fus_state_s st_q;
   fus_pkg::fus_state_s st_d;
   logic wr_go;
   logic rd_go;
   logic acc;
   logic [`FUS_AXI_AW-1:0] waddr;
   logic [`FUS_AXI_AW-1:0] raddr;
   logic key_wr;
   logic ctl_wr;
   logic start_req;
   logic restart;
   logic prot;
   logic hw_err;
   logic go;

   // ===========================================================
   // Byte-lane merge
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return res;
   endfunction : merge

   // ===========================================================
   // Bus decode
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !st_q.bvalid &&
                  !st_q.start; // R04
   assign rd_go = s_axi_arvalid && !st_q.rvalid && !st_q.start &&
                  !wr_go; // R04
   assign acc = wr_go || rd_go;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = rd_go;
   assign waddr = {s_axi_awaddr[`FUS_AXI_AW-1:2], 2'b00};
   assign raddr = {s_axi_araddr[`FUS_AXI_AW-1:2], 2'b00};
   assign key_wr = wr_go && waddr == `FUS_OFF_KEY && s_axi_wstrb[0];
   assign ctl_wr = wr_go && waddr == `FUS_OFF_CTRL && s_axi_wstrb[0];
   assign start_req = ctl_wr && s_axi_wdata[`FUS_CTL_START];
   assign restart = key_wr && s_axi_wdata[7:0] == `FUS_KEY_FIRST;
   assign prot = st_q.addr < st_q.wp_lim;

   // ===========================================================
   // Next state
   always_comb begin
      logic [31:0] tmp;
      tmp = 32'h0;
      st_d = st_q;
      hw_err = 1'b0;
      go = 1'b0;
      if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'b0;
      end
      if (st_q.rvalid && s_axi_rready) begin
         st_d.rvalid = 1'b0;
      end
      if (wr_go) begin
         st_d.bvalid = 1'b1;
         st_d.bresp = `FUS_RESP_OKAY;
         case (waddr)
            `FUS_OFF_CTRL: begin
               if (s_axi_wstrb[0]) begin
                  st_d.write_enable_bit = s_axi_wdata[`FUS_CTL_WRITE_ENABLE_BIT];
                  st_d.latches_only_select = s_axi_wdata[`FUS_CTL_LATCHES_ONLY_SELECT];
                  st_d.erase_sel = s_axi_wdata[`FUS_CTL_ERASE];
               end
            end
            `FUS_OFF_KEY: begin
               st_d.bresp = `FUS_RESP_OKAY;
            end
            `FUS_OFF_ADDR: begin
               tmp = merge({17'h0, st_q.addr}, s_axi_wdata, s_axi_wstrb);
               st_d.addr = tmp[`FUS_ADDR_W-1:0];
            end
            `FUS_OFF_DATA: begin
               tmp = merge({18'h0, st_q.data}, s_axi_wdata, s_axi_wstrb);
               st_d.data = tmp[`FUS_DATA_W-1:0];
            end
            `FUS_OFF_WPLIM: begin
               tmp = merge({17'h0, st_q.wp_lim}, s_axi_wdata, s_axi_wstrb);
               st_d.wp_lim = tmp[`FUS_ADDR_W-1:0];
            end
            default: begin
               st_d.bresp = `FUS_RESP_SLVERR;
            end
         endcase
      end
      if (rd_go) begin
         st_d.rvalid = 1'b1;
         st_d.rresp = `FUS_RESP_OKAY;
         case (raddr)
            `FUS_OFF_CTRL: begin
               st_d.rdata = {26'h0, st_q.start, st_q.erase_sel, st_q.latches_only_select,
                             st_q.err, st_q.write_enable_bit, st_q.start};
            end
            `FUS_OFF_KEY: begin
               st_d.rdata = 32'h0;
            end
            `FUS_OFF_ADDR: begin
               st_d.rdata = {17'h0, st_q.addr};
            end
            `FUS_OFF_DATA: begin
               st_d.rdata = {18'h0, st_q.data};
            end
            `FUS_OFF_WPLIM: begin
               st_d.rdata = {17'h0, st_q.wp_lim};
            end
            default: begin
               st_d.rdata = 32'h0;
               st_d.rresp = `FUS_RESP_SLVERR;
            end
         endcase
      end
      // Unlock tracker
      unique case (st_q.ul)
         fus_pkg::UL_IDLE: begin
            if (restart) begin
               st_d.ul = fus_pkg::UL_KEY1;
            end
         end
         fus_pkg::UL_KEY1: begin
            if (acc) begin
               if (key_wr && s_axi_wdata[7:0] == `FUS_KEY_SECOND) begin
                  st_d.ul = fus_pkg::UL_KEY2; // R03
               end else begin
                  hw_err = 1'b1; // R08
                  st_d.ul = restart ? fus_pkg::UL_KEY1 : fus_pkg::UL_IDLE;
               end
            end
         end
         fus_pkg::UL_KEY2: begin
            if (acc) begin
               if (start_req) begin
                  st_d.ul = fus_pkg::UL_IDLE;
                  go = st_q.write_enable_bit; // R01 R14
               end else begin
                  hw_err = 1'b1; // R08
                  st_d.ul = restart ? fus_pkg::UL_KEY1 : fus_pkg::UL_IDLE;
               end
            end
         end
      endcase
      // Operation sequencer
      unique case (st_q.op)
         fus_pkg::OP_IDLE: begin
            if (go) begin
               st_d.start = 1'b1;
               st_d.op = fus_pkg::OP_EXEC;
            end
         end
         fus_pkg::OP_EXEC: begin
            if (!st_q.erase_sel && st_q.latches_only_select) begin
               st_d.latches[st_q.addr[`FUS_IDX_W-1:0]] = st_q.data; // R11
               st_d.start = 1'b0; // R15
               st_d.op = fus_pkg::OP_IDLE;
            end else if (prot) begin
               hw_err = 1'b1; // R06 R10 R12
               st_d.start = 1'b0;
               st_d.op = fus_pkg::OP_IDLE;
            end else begin
               st_d.req = 1'b1; // R10 R12
               st_d.erase = st_q.erase_sel;
               st_d.op = fus_pkg::OP_WAIT;
            end
         end
         fus_pkg::OP_WAIT: begin
            if (flash_done) begin
               st_d.req = 1'b0;
               st_d.start = 1'b0; // R15
               st_d.op = fus_pkg::OP_IDLE;
               if (!st_q.erase) begin
                  st_d.latches = ERASED_ROW; // R13
               end
            end
         end
      endcase
      // Error flag, hardware set wins over software clear
      if (ctl_wr) begin
         st_d.err = s_axi_wdata[`FUS_CTL_ERR]; // R09
      end
      if (hw_err) begin
         st_d.err = 1'b1; // R09
      end
   end

   // ===========================================================
   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0;
         st_q.ul <= fus_pkg::UL_IDLE;
         st_q.op <= fus_pkg::OP_IDLE;
         st_q.wp_lim <= `FUS_WPLIM_RESET;
         st_q.latches <= ERASED_ROW;
         // Keep a set flag and flag an aborted operation
         if (st_q.start || st_q.err) begin
            st_q.err <= 1'b1; // R07
         end
      end else begin
         st_q <= st_d;
      end
   end

   // ===========================================================
   // Outputs
   assign s_axi_bvalid = st_q.bvalid;
   assign s_axi_bresp = st_q.bresp;
   assign s_axi_rvalid = st_q.rvalid;
   assign s_axi_rresp = st_q.rresp;
   assign s_axi_rdata = st_q.rdata;
   assign flash = '{req: st_q.req,
                    erase: st_q.erase,
                    row: st_q.addr[`FUS_ADDR_W-1:`FUS_IDX_W],
                    data: st_q.latches};
   assign cpu_stall = st_q.start; // R04

   // ===========================================================
   // Assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_unlock_done;
      st_q.ul == fus_pkg::UL_KEY2 && start_req;
   endsequence

   sequence s_key_break;
      st_q.ul == fus_pkg::UL_KEY1 && acc &&
      !(key_wr && s_axi_wdata[7:0] == `FUS_KEY_SECOND);
   endsequence

   sequence s_exec_row;
      st_q.op == fus_pkg::OP_EXEC && !(st_q.latches_only_select && !st_q.erase_sel);
   endsequence

   start_unlocked_a: assert property ( // R01
      $rose(st_q.start) |-> $past(st_q.ul) == fus_pkg::UL_KEY2 &&
                            $past(st_q.write_enable_bit))
      else $error("start set without unlock");

   key_break_a: assert property ( // R03
      s_key_break |=> st_q.err && st_q.ul != fus_pkg::UL_KEY2)
      else $error("broken key sequence not flagged");

   stall_busy_a: assert property ( // R04
      st_q.start |-> cpu_stall && !s_axi_awready && !s_axi_arready)
      else $error("bus not stalled while busy");

   protect_err_a: assert property ( // R06
      s_exec_row and prot |=> st_q.err && !st_q.start && !flash.req)
      else $error("protected start not refused");

   reset_err_a: assert property ( // R07
      @(posedge aclk) disable iff (1'b0)
      !aresetn && st_q.start |=> st_q.err)
      else $error("reset during operation not flagged");

   abort_err_a: assert property ( // R08
      st_q.ul == fus_pkg::UL_KEY2 && acc && !start_req |=> st_q.err)
      else $error("interrupted unlock not flagged");

   flag_sticky_a: assert property ( // R09
      st_q.err && !ctl_wr |=> st_q.err)
      else $error("error flag cleared by hardware");

   row_request_a: assert property ( // R10
      s_exec_row and !prot |=> flash.req && st_q.start &&
      flash.erase == $past(st_q.erase_sel) && st_q.op == fus_pkg::OP_WAIT)
      else $error("row operation not requested");

   latch_load_a: assert property ( // R11
      st_q.op == fus_pkg::OP_EXEC && st_q.latches_only_select && !st_q.erase_sel |=>
      st_q.latches[$past(st_q.addr[`FUS_IDX_W-1:0])] == $past(st_q.data)
      && !flash.req && !st_q.start)
      else $error("latch load wrong");

   latch_reset_a: assert property ( // R13
      st_q.op == fus_pkg::OP_WAIT && !st_q.erase && flash_done |=>
      st_q.latches == ERASED_ROW)
      else $error("latches not erased after row write");

   write_enable_bit_gate_a: assert property ( // R14
      s_unlock_done and !st_q.write_enable_bit |=> !st_q.start ##1 !st_q.start)
      else $error("start without write enable");

   done_clear_a: assert property ( // R15
      st_q.op == fus_pkg::OP_WAIT && flash_done |=> !st_q.start && !flash.req)
      else $error("start not cleared at completion");

   key_advance_a: assert property ( // R03
      st_q.ul == fus_pkg::UL_KEY1 && key_wr &&
      s_axi_wdata[7:0] == `FUS_KEY_SECOND |=> st_q.ul == fus_pkg::UL_KEY2)
      else $error("second key not accepted");

   req_hold_a: assert property ( // R04
      flash.req && !flash_done |=> flash.req && st_q.start)
      else $error("flash request dropped early");

   err_soft_a: assert property ( // R09
      ctl_wr && s_axi_wdata[`FUS_CTL_ERR] |=> st_q.err)
      else $error("software set of error flag lost");

   latch_keep_a: assert property ( // R01
      st_q.op == fus_pkg::OP_IDLE |=> $stable(st_q.latches))
      else $error("latches changed without operation");

   erase_keep_a: assert property ( // R10
      st_q.op == fus_pkg::OP_WAIT && st_q.erase && flash_done |=>
      $stable(st_q.latches))
      else $error("row erase disturbed latches");
endmodule : fus_sequencer
`default_nettype wire

// ===== core/fus_defs.svh
// Constants of the flash unlock and write sequencer
// Operation
// R01: Erase, latch load, row write and user-ID write need a full unlock.
// R02: The unlock is 55h then AAh to the key register, then the start bit set.
// R03: The three steps follow back to back, or the sequence is refused.
// R04: While the start bit is set the core is stalled until the operation ends.
// R05: Software masks interrupts from the first key write until start is set.
// R06: Start on a write-protected address sets the error flag; the code does not flag a latch-only load.
// R07: A reset during a running operation sets the error flag.
// R08: A broken unlock sequence sets the error flag.
// R09: Software may set the error flag; only software ever clears it.
// R10: Erase select erases the addressed 32-word row, or flags if protected.
// R11: Latch-only select loads the data word into the addressed latch.
// R12: Neither select writes the latches to the row, or flags if protected.
// R13: After a row write every latch returns to 3FFh.
// R14: With write enable clear a start does not begin any erase or write; the code checks the write enable stored before the start write.
// R15: Hardware clears the start bit when the operation completes.
`ifndef FUS_DEFS_SVH
`define FUS_DEFS_SVH
// ===========================================================
// Widths
`define FUS_AXI_AW 8
`define FUS_ADDR_W 15
`define FUS_DATA_W 14
`define FUS_ROW_WORDS 32
`define FUS_IDX_W 5
`define FUS_ROW_W 10
// ===========================================================
// Keys and values
`define FUS_KEY_FIRST 8'h55
`define FUS_KEY_SECOND 8'haa
`define FUS_LATCH_ERASED 14'h03ff
`define FUS_WPLIM_RESET 15'h0000
// ===========================================================
// Register offsets
`define FUS_OFF_CTRL 8'h00
`define FUS_OFF_KEY 8'h04
`define FUS_OFF_ADDR 8'h08
`define FUS_OFF_DATA 8'h0c
`define FUS_OFF_WPLIM 8'h10
// ===========================================================
// Control register fields
`define FUS_CTL_START 0
`define FUS_CTL_WRITE_ENABLE_BIT 1
`define FUS_CTL_ERR 2
`define FUS_CTL_LATCHES_ONLY_SELECT 3
`define FUS_CTL_ERASE 4
`define FUS_CTL_BUSY 5
// ===========================================================
// Bus responses
`define FUS_RESP_OKAY 2'b00
`define FUS_RESP_SLVERR 2'b10
`endif

// ===== core/fus_pkg.sv
// Types of the flash unlock and write sequencer
`include "fus_defs.svh"
`default_nettype none
package fus_pkg;
   typedef enum logic [2:0] {
      UL_IDLE = 3'b001,
      UL_KEY1 = 3'b010,
      UL_KEY2 = 3'b100
   } fus_unlock_e;
   typedef enum logic [2:0] {
      OP_IDLE = 3'b001,
      OP_EXEC = 3'b010,
      OP_WAIT = 3'b100
   } fus_op_e;
   typedef logic [`FUS_ROW_WORDS-1:0][`FUS_DATA_W-1:0] fus_latch_t;
   typedef struct packed {
      logic req;
      logic erase;
      logic [`FUS_ROW_W-1:0] row;
      fus_latch_t data;
   } fus_flash_s;
   typedef struct packed {
      fus_unlock_e ul;
      fus_op_e op;
      logic start;
      logic write_enable_bit;
      logic err;
      logic latches_only_select;
      logic erase_sel;
      logic [`FUS_ADDR_W-1:0] addr;
      logic [`FUS_DATA_W-1:0] data;
      logic [`FUS_ADDR_W-1:0] wp_lim;
      fus_latch_t latches;
      logic req;
      logic erase;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } fus_state_s;
endpackage : fus_pkg
`default_nettype wire

// ===== test/fus_flash_model.sv
// Behavioural flash array answering the sequencer's requests
`default_nettype none
module fus_flash_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire fus_pkg::fus_flash_s flash,
   input wire logic [7:0] latency,
   output logic flash_done
);
   timeunit 1ns;
   timeprecision 1ns;
   logic busy_q;
   logic [7:0] cnt_q;
   // ==========================================================
   // Array timing
   // Counts out the array time, then pulses done for one cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         busy_q <= 1'b0;
         cnt_q <= 8'h00;
         flash_done <= 1'b0;
      end else begin
         flash_done <= 1'b0;
         if (busy_q && cnt_q == 8'h00) begin
            busy_q <= 1'b0;
            flash_done <= 1'b1;
         end else if (busy_q) begin
            cnt_q <= cnt_q - 8'h01;
         end else if (flash.req && !flash_done) begin
            busy_q <= 1'b1;
            cnt_q <= latency;
         end
      end
   end
endmodule : fus_flash_model
`default_nettype wire

// ===== test/tb_flash_unlock_write_sequencer.sv
// Self-checking bench of the flash unlock and write sequencer
`include "fus_defs.svh"
`default_nettype none
`define TB_CHK(g, e) \
   begin \
      comparisons++; \
      if ((g) !== (e)) begin \
         err_total++; \
         $display("Error %0t: got %h want %h", $time, g, e); \
      end \
   end
module tb_flash_unlock_write_sequencer;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, latency = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, flash_done, cpu_stall;
   logic [1:0] bresp, rresp, last_resp;
   fus_pkg::fus_flash_s flash;
   logic [13:0] exp_lat [32];
   logic [14:0] cur_addr;
   logic [31:0] seed = 32'h74b5;
   logic req_prev = 1'b0;
   int err_total = 0, comparisons = 0, cycles = 0;
   int req_rises = 0, exp_req = 0;
   // ==========================================================
   // Design, flash model and clock
   fus_sequencer uut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .flash(flash),
      .flash_done(flash_done), .cpu_stall(cpu_stall));
   fus_flash_model flash_arr (.aclk(aclk), .aresetn(aresetn),
      .flash(flash), .latency(latency), .flash_done(flash_done));
   always #50 aclk = ~aclk;
   always @(posedge aclk) begin
      cycles++;
      req_prev <= flash.req;
      if (flash.req === 1'b1 && req_prev === 1'b0) req_rises++;
      if (cycles == 20000) begin
         err_total++;
         finish_test();
      end
   end
   // ==========================================================
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   function automatic fus_pkg::fus_latch_t pack_lat();
      fus_pkg::fus_latch_t p;
      for (int i = 0; i < 32; i++) p[i] = exp_lat[i];
      return p;
   endfunction : pack_lat
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge aclk); while (awready !== 1'b1 || wready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge aclk); while (bvalid !== 1'b1);
      last_resp = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      last_resp = rresp;
      rready <= 1'b0;
   endtask : rd
   task automatic set_ad(input logic [14:0] a, input logic [13:0] v);
      wr(`FUS_OFF_ADDR, {17'h0, a});
      wr(`FUS_OFF_DATA, {18'h0, v});
      cur_addr = a;
   endtask : set_ad
   task automatic unl(input logic [31:0] ctl);
      wr(`FUS_OFF_KEY, 32'h55);
      wr(`FUS_OFF_KEY, 32'haa);
      wr(`FUS_OFF_CTRL, ctl);
   endtask : unl
   task automatic run_op(input logic [31:0] ctl, input logic go,
                         input logic e, input logic [13:0] v);
      logic [31:0] d;
      unl(ctl);
      `TB_CHK(last_resp, `FUS_RESP_OKAY)
      if (go) begin
         while (flash.req !== 1'b1) @(posedge aclk);
         exp_req++;
         `TB_CHK(cpu_stall, 1'b1)
         `TB_CHK(flash.erase, ctl[4])
         `TB_CHK(flash.row, cur_addr[14:5])
         if (!ctl[4]) `TB_CHK(flash.data, pack_lat())
         while (flash_done !== 1'b1) @(posedge aclk);
         if (!ctl[4]) for (int i = 0; i < 32; i++) exp_lat[i] = 14'h03ff;
      end
      if (ctl[3] && !ctl[4] && ctl[1]) exp_lat[cur_addr[4:0]] = v;
      rd(`FUS_OFF_CTRL, d);
      `TB_CHK(d[2:0], {e, ctl[1], 1'b0})
      `TB_CHK(cpu_stall, 1'b0)
      `TB_CHK(flash.data, pack_lat())
   endtask : run_op
   task automatic finish_test();
      $display("Comparisons %0d, errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test
   // ==========================================================
   // Scenarios
   initial begin
      logic [31:0] d;
      logic [31:0] ctl;
      for (int i = 0; i < 32; i++) exp_lat[i] = 14'h03ff;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`FUS_OFF_CTRL, d);
      `TB_CHK(d[5:0], 6'h00)
      `TB_CHK(flash.data, pack_lat())
      rd(8'h40, d);
      `TB_CHK({last_resp, d}, {2'b10, 32'h0})
      wr(8'h44, 32'h1);
      `TB_CHK(last_resp, 2'b10)
      wr(`FUS_OFF_CTRL, 32'h2);
      latency <= 8'd6;
      seed = xs(seed);
      cur_addr = seed[14:0];
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         d = {27'h0, (i == 0) ? 5'h1f : seed[4:0]};
         set_ad({cur_addr[14:5], d[4:0]}, seed[29:16]);
         run_op(32'h0b, 1'b0, 1'b0, seed[29:16]);
      end
      run_op(32'h03, 1'b1, 1'b0, 14'h0);
      seed = xs(seed);
      set_ad(seed[14:0], seed[29:16]);
      latency <= 8'd0;
      run_op(32'h1b, 1'b1, 1'b0, 14'h0);
      wr(`FUS_OFF_WPLIM, 32'h7fff);
      for (int k = 0; k < 3; k++) begin
         ctl = (k == 0) ? 32'h13 : (k == 1) ? 32'h03 : 32'h0b;
         seed = xs(seed);
         set_ad({1'b0, seed[13:0]}, seed[29:16]);
         run_op(ctl, 1'b0, k != 2, seed[29:16]);
         wr(`FUS_OFF_CTRL, 32'h2);
      end
      wr(`FUS_OFF_WPLIM, 32'h0);
      for (int k = 0; k < 3; k++) begin
         wr(`FUS_OFF_KEY, 32'h55);
         if (k == 1) wr(`FUS_OFF_KEY, 32'haa);
         if (k == 0) rd(`FUS_OFF_CTRL, d);
         else if (k == 1) wr(`FUS_OFF_ADDR, {17'h0, cur_addr});
         else wr(`FUS_OFF_KEY, 32'h12);
         rd(`FUS_OFF_CTRL, d);
         `TB_CHK(d[2], 1'b1)
         wr(`FUS_OFF_CTRL, 32'h3);
         rd(`FUS_OFF_CTRL, d);
         `TB_CHK(d[2:0], 3'b010)
      end
      wr(`FUS_OFF_CTRL, 32'h0);
      run_op(32'h11, 1'b0, 1'b0, 14'h0);
      wr(`FUS_OFF_CTRL, 32'h6);
      wr(`FUS_OFF_DATA, 32'h0);
      repeat (5) @(posedge aclk);
      rd(`FUS_OFF_CTRL, d);
      `TB_CHK(d[2:0], 3'b110)
      wr(`FUS_OFF_CTRL, 32'h2);
      latency <= 8'd40;
      unl(32'h03);
      while (flash.req !== 1'b1) @(posedge aclk);
      exp_req++;
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 32; i++) exp_lat[i] = 14'h03ff;
      rd(`FUS_OFF_CTRL, d);
      `TB_CHK({d[2], d[0], flash.req}, 3'b100)
      `TB_CHK(flash.data, pack_lat())
      `TB_CHK(req_rises, exp_req)
      finish_test();
   end
endmodule : tb_flash_unlock_write_sequencer
`default_nettype wire
